// *** rtl/ccrb_pkg.sv ***
// Package for the charger control register bank: map, fields, resets, types
package ccrb_pkg;

  // Register pointers on the serial link
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CHARGER = 8'h01;
  localparam logic [7:0] REG_REGV = 8'h02;
  localparam logic [7:0] REG_IDENT = 8'h03;
  localparam logic [7:0] REG_COUNT = 8'h04;

  // Seven-bit target address on the link
  localparam logic [6:0] DEV_ADDR = 7'h35;

  // Status and control field positions
  localparam int STAT_TIMER_BIT = 7;
  localparam int STAT_ALLOW_BIT = 6;

  // Reset values
  localparam logic STAT_ALLOW_RESET = 1'b1;
  localparam logic [7:0] CHARGER_RESET = 8'h30;
  localparam logic [7:0] REGV_RESET = 8'h0A;

  // Identification fields, values arbitrary
  localparam logic [2:0] MAKER_CODE = 3'h5;
  localparam logic [1:0] PART_CODE = 2'h2;
  localparam logic [2:0] REVISION_CODE = 3'h0;

  // Threshold scaling in millivolts
  localparam logic [12:0] WEAK_OFFSET_MV = 13'h0D48;
  localparam logic [12:0] WEAK_STEP_MV = 13'h0064;
  localparam logic [12:0] REG_OFFSET_MV = 13'h0DAC;
  localparam logic [12:0] REG_STEP_MV = 13'h0014;

  typedef enum logic [1:0] {
    PHASE_READY = 2'h0,
    PHASE_CHARGING = 2'h1,
    PHASE_DONE = 2'h2,
    PHASE_FAULT = 2'h3
  } ccrb_phase_t;

  typedef enum logic [2:0] {
    CERR_NORMAL = 3'h0, CERR_IN_OVP = 3'h1, CERR_SLEEP = 3'h2, CERR_POOR_SRC = 3'h3,
    CERR_OUT_OVP = 3'h4, CERR_THERMAL = 3'h5, CERR_TIMER = 3'h6, CERR_NO_BATT = 3'h7
  } ccrb_charge_err_t;

  typedef enum logic [2:0] {
    BERR_NORMAL = 3'h0, BERR_IN_OVP = 3'h1, BERR_OVERLOAD = 3'h2, BERR_BATT_LOW = 3'h3,
    BERR_BATT_OVP = 3'h4, BERR_THERMAL = 3'h5, BERR_TIMER = 3'h6, BERR_UNUSED = 3'h7
  } ccrb_boost_err_t;

  typedef struct packed {
    logic [1:0] input_current_cap;
    logic [1:0] weak_cell_threshold;
    logic end_of_charge_cutoff_on;
    logic charger_inhibit;
    logic input_float_select;
    logic boost_select;
  } ccrb_charger_t;

  typedef struct packed {
    logic [5:0] regulation_code;
    logic host_pin_polarity;
    logic host_pin_allow;
  } ccrb_regv_t;

  typedef struct packed {
    ccrb_phase_t charge_phase;
    logic boost_active;
    logic [2:0] error_code;
  } ccrb_status_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } ccrb_state_t;

endpackage

// *** rtl/ccrb_charger_regs.sv ***
// Charger control register bank with serial slave on its own link clock
`timescale 1ns/1ns

// Overview of operation
// - Writing one to status bit 7 restarts the safety timer; the bit self-clears.
// - Reading status bit 7 returns the current OTG pin level.
// - Status bit 6 enables the status pin function; resets to one.
// - Status bits 5:4 report ready, charging, done or fault.
// - Status bit 3 reads one while in boost mode.
// - In charge mode bits 2:0 give the charge fault code.
// - In boost mode bits 2:0 give the boost fault code.
// - Charger bits 7:6 pick 100, 500, 800 mA or no limit; reset 00.
// - Charger bits 5:4 set weak threshold 3.4 V plus 200/100 mV; reset ones.
// - Charger bit 3 enables charge termination; resets to zero.
// - Charger bit 2 disables the charger; resets to zero.
// - Charger bit 1 selects high-impedance mode; resets to zero.
// - Charger bit 0 selects boost mode; resets to zero.
// - Voltage bits 7:2 add 20 mV steps to 3.5 V; only 40 mV bit resets set.
// - Voltage bit 1 makes the OTG input active high; resets to one.
// - Voltage bit 0 enables the OTG input pin; resets to zero.
// - Identification register holds maker and part codes, unchanged by writes.
module ccrb_charger_regs (
  // System
  input logic clk,
  input logic reset_n,
  // Serial link
  input logic scl,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Pins and charger core
  input logic otg_pin,
  input ccrb_pkg::ccrb_status_t core_status,
  // Control outputs
  output logic safety_timer_restart,
  output logic indicator_pin_allow,
  output ccrb_pkg::ccrb_charger_t charger_ctrl,
  output ccrb_pkg::ccrb_regv_t regv_ctrl,
  output logic otg_request,
  output logic [12:0] weak_threshold_mv,
  output logic [12:0] regulation_mv
);
  import ccrb_pkg::*;

  logic rst_meta_reg;
  logic rst_n_sync;

  // Link domain
  logic start_tgl_reg;
  logic start_seen_reg;
  logic start_pending;
  ccrb_state_t state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] byte_in;
  logic [7:0] ptr_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic wr_tgl_reg;
  logic snap_req_reg;
  logic [2:0] ack_sync_reg;
  logic snap_ready;
  logic [7:0] rbyte;
  logic [7:0] tx_reg;
  logic drive_low_reg;

  // System domain
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] stable_reg;
  logic [2:0] event_in;
  logic otg_level;
  logic wr_event;
  logic snap_event;
  logic snap_ack_reg;
  logic [7:0] image [0:3];
  logic [7:0] snap_reg [0:3];
  logic restart_reg;
  logic allow_reg;
  ccrb_charger_t charger_reg;
  ccrb_regv_t regv_reg;
  logic otg_req_reg;
  logic [12:0] weak_mv_reg;
  logic [12:0] reg_mv_reg;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // START: data falls while the link clock is high
  always_ff @(negedge sda_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      start_tgl_reg <= 1'b0;
    end else if (scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  // START hold time guarantees the toggle is settled at the next rising edge
  assign start_pending = start_tgl_reg ^ start_seen_reg;
  assign byte_in = {shift_reg[6:0], sda_i};

  // Bit sampling, framing and pointer on the rising link edge
  always_ff @(posedge scl or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      start_seen_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      wr_tgl_reg <= 1'b0;
      snap_req_reg <= 1'b0;
    end else if (start_pending) begin
      start_seen_reg <= start_tgl_reg;
      snap_req_reg <= ~snap_req_reg;
      state_reg <= ST_ADDR;
      shift_reg <= {7'h00, sda_i};
      cnt_reg <= 3'h1;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          shift_reg <= byte_in;
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            if (shift_reg[6:0] == DEV_ADDR) begin
              state_reg <= ST_AACK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          cnt_reg <= 3'h0;
          if (shift_reg[0]) begin
            state_reg <= ST_RDATA;
          end else begin
            state_reg <= ST_PTR;
          end
        end
        ST_PTR: begin
          shift_reg <= byte_in;
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            ptr_reg <= byte_in;
            state_reg <= ST_PACK;
          end
        end
        ST_PACK: begin
          cnt_reg <= 3'h0;
          state_reg <= ST_WDATA;
        end
        ST_WDATA: begin
          shift_reg <= byte_in;
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= byte_in;
            wr_tgl_reg <= ~wr_tgl_reg;
            ptr_reg <= ptr_reg + 8'h01;
            state_reg <= ST_WACK;
          end
        end
        ST_WACK: begin
          cnt_reg <= 3'h0;
          state_reg <= ST_WDATA;
        end
        ST_RDATA: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            ptr_reg <= ptr_reg + 8'h01;
            state_reg <= ST_RACK;
          end
        end
        ST_RACK: begin
          cnt_reg <= 3'h0;
          if (sda_i) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_RDATA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Snapshot acknowledge back into the link domain
  always_ff @(posedge scl or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ack_sync_reg <= 3'h0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[1:0], snap_ack_reg};
    end
  end

  assign snap_ready = (ack_sync_reg[1] == ack_sync_reg[2]) && (ack_sync_reg[2] == snap_req_reg);

  // Unmapped pointer or missing snapshot reads as zero
  always_comb begin
    rbyte = 8'h00;
    if (snap_ready && (ptr_reg < REG_COUNT)) begin
      rbyte = snap_reg[ptr_reg[1:0]];
    end
  end

  // Acknowledge and read data driven on the falling link edge
  always_ff @(negedge scl or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      drive_low_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_AACK, ST_PACK, ST_WACK: begin
          drive_low_reg <= 1'b1;
        end
        ST_RDATA: begin
          if (cnt_reg == 3'h0) begin
            drive_low_reg <= ~rbyte[7];
            tx_reg <= {rbyte[6:0], 1'b0};
          end else begin
            drive_low_reg <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        default: begin
          drive_low_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive_low_reg;

  // Pin and toggle synchronisers: OTG pin, write toggle, snapshot request
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else begin
      s1_reg <= {snap_req_reg, wr_tgl_reg, otg_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_stable
      assign event_in[gi] = (s2_reg[gi] == s3_reg[gi]) && (s3_reg[gi] != stable_reg[gi]);
      always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          stable_reg[gi] <= 1'b0;
        end else if (event_in[gi]) begin
          stable_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  assign otg_level = stable_reg[0];
  assign wr_event = event_in[1];
  assign snap_event = event_in[2];

  // Live image of all four registers
  always_comb begin
    image[0] = {otg_level, allow_reg, core_status};
    image[1] = charger_reg;
    image[2] = regv_reg;
    image[3] = {MAKER_CODE, PART_CODE, REVISION_CODE};
  end

  // Snapshot taken per START, held stable for the link domain
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      snap_ack_reg <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        snap_reg[i] <= 8'h00;
      end
    end else if (snap_event) begin
      snap_ack_reg <= s3_reg[2];
      for (int i = 0; i < 4; i++) begin
        snap_reg[i] <= image[i];
      end
    end
  end

  // Safety timer restart is a one-cycle pulse, never stored
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_event && (wr_addr_reg == REG_STATUS) && wr_data_reg[STAT_TIMER_BIT];
    end
  end

  // Status pin enable; status bits 5:0 are read-only, a write to bit 7 only pulses the timer restart
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      allow_reg <= STAT_ALLOW_RESET;
    end else if (wr_event && (wr_addr_reg == REG_STATUS)) begin
      allow_reg <= wr_data_reg[STAT_ALLOW_BIT];
    end
  end

  // Charger control register
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      charger_reg <= CHARGER_RESET;
    end else if (wr_event && (wr_addr_reg == REG_CHARGER)) begin
      charger_reg <= wr_data_reg;
    end
  end

  // Regulation voltage and OTG pin configuration
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      regv_reg <= REGV_RESET;
    end else if (wr_event && (wr_addr_reg == REG_REGV)) begin
      regv_reg <= wr_data_reg;
    end
  end

  // OTG request and scaled thresholds
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      otg_req_reg <= 1'b0;
      weak_mv_reg <= 13'(WEAK_OFFSET_MV + WEAK_STEP_MV * CHARGER_RESET[5:4]);
      reg_mv_reg <= 13'(REG_OFFSET_MV + REG_STEP_MV * REGV_RESET[7:2]);
    end else begin
      otg_req_reg <= regv_reg.host_pin_allow && (otg_level == regv_reg.host_pin_polarity);
      weak_mv_reg <= 13'(WEAK_OFFSET_MV + charger_reg.weak_cell_threshold * WEAK_STEP_MV);
      reg_mv_reg <= 13'(REG_OFFSET_MV + regv_reg.regulation_code * REG_STEP_MV);
    end
  end

  assign safety_timer_restart = restart_reg;
  assign indicator_pin_allow = allow_reg;
  assign charger_ctrl = charger_reg;
  assign regv_ctrl = regv_reg;
  assign otg_request = otg_req_reg;
  assign weak_threshold_mv = weak_mv_reg;
  assign regulation_mv = reg_mv_reg;

endmodule

// *** testbench/ccrb_charger_regs_sva.sv ***
// Port assertions for the charger control register bank
`timescale 1ns/1ns
module ccrb_charger_regs_sva (
  // System
  input logic clk,
  input logic reset_n,
  // Link and pin
  input logic scl,
  input logic sda_oe_n,
  input logic otg_pin,
  // Controls
  input logic safety_timer_restart,
  input logic indicator_pin_allow,
  input ccrb_pkg::ccrb_charger_t charger_ctrl,
  input ccrb_pkg::ccrb_regv_t regv_ctrl,
  input logic otg_request,
  input logic [12:0] weak_threshold_mv,
  input logic [12:0] regulation_mv
);
  import ccrb_pkg::*;
  logic scl_q;
  logic [3:0] quiet_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles since the link clock last moved
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      quiet_cnt <= 4'hF;
    end else begin
      scl_q <= scl;
      quiet_cnt <= (scl != scl_q) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hF};
    end
  end
  a_restart_pulse: assert property (safety_timer_restart |=> !safety_timer_restart [*8])
    else $error("restart pulse too long");
  a_restart_by_link: assert property (safety_timer_restart |-> quiet_cnt < 4'hC)
    else $error("restart without link write");
  a_reset_values: assert property ($rose(reset_n) |-> charger_ctrl == CHARGER_RESET
    && regv_ctrl == REGV_RESET && indicator_pin_allow && sda_oe_n && !safety_timer_restart)
    else $error("bad value at reset release");
  a_weak_level: assert property ($stable(charger_ctrl) [*2] |->
    weak_threshold_mv == WEAK_OFFSET_MV + WEAK_STEP_MV * charger_ctrl.weak_cell_threshold)
    else $error("weak threshold mismatch");
  a_regv_level: assert property ($stable(regv_ctrl) [*2] |->
    regulation_mv == REG_OFFSET_MV + REG_STEP_MV * regv_ctrl.regulation_code)
    else $error("regulation level mismatch");
  a_otg_request: assert property (($stable(otg_pin) && $stable(regv_ctrl)) [*8] |->
    otg_request == (regv_ctrl.host_pin_allow && otg_pin == regv_ctrl.host_pin_polarity))
    else $error("otg request mismatch");
  a_ctrl_by_link: assert property (!$stable(charger_ctrl) || !$stable(indicator_pin_allow) |->
    quiet_cnt < 4'hC)
    else $error("charger control changed without link write");
  a_regv_by_link: assert property (!$stable(regv_ctrl) |-> quiet_cnt < 4'hC)
    else $error("voltage control changed without link write");
endmodule
bind ccrb_charger_regs ccrb_charger_regs_sva i_sva (.clk(clk), .reset_n(reset_n), .scl(scl), .sda_oe_n(sda_oe_n),
  .otg_pin(otg_pin), .safety_timer_restart(safety_timer_restart), .indicator_pin_allow(indicator_pin_allow),
  .charger_ctrl(charger_ctrl), .regv_ctrl(regv_ctrl), .otg_request(otg_request),
  .weak_threshold_mv(weak_threshold_mv), .regulation_mv(regulation_mv));

// *** testbench/ccrb_host_model.sv ***
// Serial host master model for the register link
`timescale 1ns/1ns
module ccrb_host_model (
  // Link
  output logic scl,
  output logic sda,
  input logic sda_in
);
  import ccrb_pkg::*;
  // Clock idles high between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    #20 scl = 1'b1;
    #20 r = sda_in;
    #20 scl = 1'b0;
    #20;
  endtask
  // Offset shifts link edges by 7 ns per START; back-to-back transfers still land some on system clock edges
  task automatic start;
    #7 sda = 1'b1;
    #20 scl = 1'b1;
    #20 sda = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask
  task automatic stop;
    sda = 1'b0;
    #20 scl = 1'b1;
    #20 sda = 1'b1;
    #20;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx = {rx[6:0], r};
    end
    bit_io(1'b1, ack);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start;
    xfer({DEV_ADDR, 1'b0}, rx, a0);
    xfer(ptr, rx, a1);
    xfer(dat, rx, a2);
    stop;
    ok = !(a0 | a1 | a2);
  endtask
  // Released ninth bit ends each read with a refusal
  task automatic rd(input logic [7:0] ptr, output logic [7:0] dat);
    logic [7:0] rx;
    logic a;
    start;
    xfer({DEV_ADDR, 1'b0}, rx, a);
    xfer(ptr, rx, a);
    start;
    xfer({DEV_ADDR, 1'b1}, rx, a);
    xfer(8'hFF, dat, a);
    stop;
  endtask
endmodule

// *** testbench/ccrb_charger_regs_bench.sv ***
// Self-checking bench for the charger control register bank
`timescale 1ns/1ns
module ccrb_charger_regs_bench;
  import ccrb_pkg::*;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] wdat;
    logic [7:0] rdat;
  } ccrb_row_t;
  localparam ccrb_row_t ROWS [6] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h01, 8'h5A, 8'h5A}, '{8'h02, 8'hFF, 8'hFF},
    '{8'h02, 8'h01, 8'h01}, '{8'h03, 8'hFF, {MAKER_CODE, PART_CODE, REVISION_CODE}}, '{8'h04, 8'h55, 8'h00}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic otg_pin = 1'b0;
  ccrb_status_t core_status = '0;
  logic scl, host_sda, sda_wire, sda_o, sda_oe_n, restart, allow, otg_request, ok;
  ccrb_charger_t charger_ctrl;
  ccrb_regv_t regv_ctrl;
  logic [12:0] weak_mv, reg_mv;
  logic [7:0] rdat;
  int error_cnt = 0;
  int checks_done = 0;
  int pulses = 0;
  int n;
  always #5 clk = ~clk;
  always @(posedge clk) if (restart === 1'b1) pulses++;
  // Open-drain wire with pull-up
  assign sda_wire = host_sda & (sda_oe_n | sda_o);
  ccrb_host_model i_host (.scl(scl), .sda(host_sda), .sda_in(sda_wire));
  ccrb_charger_regs i_dut (.clk(clk), .reset_n(reset_n), .scl(scl), .sda_i(sda_wire), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .otg_pin(otg_pin), .core_status(core_status), .safety_timer_restart(restart),
    .indicator_pin_allow(allow), .charger_ctrl(charger_ctrl), .regv_ctrl(regv_ctrl), .otg_request(otg_request),
    .weak_threshold_mv(weak_mv), .regulation_mv(reg_mv));
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole run needs about 90 us
  initial begin
    #300000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ROWS[i]) begin
      i_host.wr(ROWS[i].ptr, ROWS[i].wdat, ok);
      i_host.rd(ROWS[i].ptr, rdat);
      check(rdat, ROWS[i].rdat);
      if (ROWS[i].ptr == REG_CHARGER) begin
        check(charger_ctrl, ROWS[i].wdat);
        check(weak_mv, WEAK_OFFSET_MV + WEAK_STEP_MV * ROWS[i].wdat[5:4]);
      end
      if (ROWS[i].ptr == REG_REGV) begin
        check(regv_ctrl, ROWS[i].wdat);
        check(reg_mv, REG_OFFSET_MV + REG_STEP_MV * ROWS[i].wdat[7:2]);
      end
      $display("row %0d done", i);
    end
    @(posedge clk) otg_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check(otg_request, 1'b0);
    @(posedge clk) otg_pin <= 1'b0;
    repeat (10) @(posedge clk);
    check(otg_request, 1'b1);
    // Active-high polarity with the pin enabled
    i_host.wr(REG_REGV, 8'h03, ok);
    @(posedge clk) otg_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check(otg_request, 1'b1);
    $display("otg test done");
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      otg_pin <= n[0];
      core_status <= ccrb_status_t'({n[1:0], n[2], n[2:0]});
      i_host.wr(REG_STATUS, {1'b0, n[1], 6'h2A}, ok);
      i_host.rd(REG_STATUS, rdat);
      check(rdat, {n[0], n[1], n[1:0], n[2], n[2:0]});
      check(allow, n[1]);
    end
    $display("status test done");
    @(posedge clk) otg_pin <= 1'b0;
    repeat (10) @(posedge clk);
    n = pulses;
    i_host.wr(REG_STATUS, 8'hC0, ok);
    i_host.rd(REG_STATUS, rdat);
    check(pulses - n, 1);
    check(ok, 1'b1);
    check(rdat, 8'h7F);
    check(sda_o, 1'b0);
    $display("restart test done");
    @(posedge clk) reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(charger_ctrl, CHARGER_RESET);
    check(regv_ctrl, REGV_RESET);
    check(allow, 1'b1);
    check(weak_mv, WEAK_OFFSET_MV + WEAK_STEP_MV * 2'h3);
    check(reg_mv, REG_OFFSET_MV + REG_STEP_MV * 2'h2);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    i_host.rd(REG_CHARGER, rdat);
    check(rdat, CHARGER_RESET);
    i_host.rd(REG_REGV, rdat);
    check(rdat, REGV_RESET);
    $display("reset test done");
    test_done;
  end
endmodule
